// >>> verilog/toc_unit.sv
`timescale 1ns/10ps

module toc_unit
	import toc_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [TOC_ADDR_W-1:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic [15:0] counter_value_i,
	input wire logic timer_tick_i,
	input wire logic counter_at_top_i,
	input wire logic counter_at_bottom_i,
	input wire logic counter_write_i,
	input wire logic [1:0] irq_ack_i,
	input wire logic [1:0] port_data_i,
	input wire logic [1:0] pin_direction_bit_i,
	output logic [1:0] pin_out_o,
	output logic [1:0] pin_oe_o,
	output logic [1:0] irq_o,
	output logic [3:0] waveform_mode_sel_o,
	output logic [15:0] top_value_o,
	output logic top_from_a_o,
	output logic top_match_o
);

	// ------------------------------------------------------------
	// mode decoding
	// ------------------------------------------------------------

	// twelve PWM modes: everything except normal, both ctc and reserved
	function automatic logic is_pwm(input logic [3:0] m);
		is_pwm = !(m == TOC_WGM_NORMAL || m == TOC_WGM_CTC_A ||
			m == TOC_WGM_CTC_CAP || m == TOC_WGM_RESERVED);
	endfunction : is_pwm

	// single-slope modes
	function automatic logic is_fast(input logic [3:0] m);
		is_fast = (m == TOC_WGM_FAST_8 || m == TOC_WGM_FAST_9 ||
			m == TOC_WGM_FAST_10 || m == TOC_WGM_FAST_CAP ||
			m == TOC_WGM_FAST_A);
	endfunction : is_fast

	// modes whose TOP is channel A's compare value
	function automatic logic a_is_top(input logic [3:0] m);
		a_is_top = (m == TOC_WGM_CTC_A || m == TOC_WGM_FAST_A ||
			m == TOC_WGM_PFC_A || m == TOC_WGM_PC_A);
	endfunction : a_is_top

	// non-PWM reaction of an output state to a match or a force
	function automatic logic plain_action(input logic [1:0] a, input logic s);
		case (a)
			TOC_ACT_TOGGLE: plain_action = ~s;
			TOC_ACT_CLEAR: plain_action = 1'b0;
			TOC_ACT_SET: plain_action = 1'b1;
			default: plain_action = s;
		endcase
	endfunction : plain_action

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	toc_state_s q;
	toc_state_s d;
	logic [1:0] equal;
	logic [1:0] real_match;
	logic pwm;
	logic fast;

	assign pwm = is_pwm(q.mode);
	assign fast = is_fast(q.mode);

	// ------------------------------------------------------------
	// comparators, one per channel
	// ------------------------------------------------------------
	genvar ch;
	generate
		for (ch = 0; ch < TOC_NCH; ch++) begin : g_cmp
			// full-width compare, evaluated every cycle
			assign equal[ch] = (counter_value_i == q.cmp_act[ch]);
			// a counter write blanks the next tick, even a TOP hit
			assign real_match[ch] = timer_tick_i & equal[ch] & ~q.block;
		end
	endgenerate

	// ------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------
	always_comb begin
		logic [15:0] wr_val;
		logic buf_load;
		logic [7:0] rd_val;
		wr_val = {q.temp, reg_wdata_i};
		buf_load = 1'b0;
		rd_val = TOC_BYTE_RST;
		d = q;

		// blocking window: armed by a counter write, spent by the next tick;
		// held while the timer is stopped so the first real tick is covered
		if (counter_write_i) begin
			d.block = 1'b1;
		end else if (timer_tick_i) begin
			d.block = 1'b0;
		end

		// buffered compare copies over at TOP for single slope, else BOTTOM
		if (pwm && timer_tick_i) begin
			buf_load = fast ? counter_at_top_i : counter_at_bottom_i;
		end
		if (buf_load) begin
			d.cmp_act = q.cmp_buf;
		end

		for (int i = 0; i < TOC_NCH; i++) begin
			// match seen on one tick, flag lands on the next one
			if (timer_tick_i) begin
				d.pend[i] = real_match[i];
			end
			// clears first so a same-cycle set still wins
			if (irq_ack_i[i]) begin
				d.flag[i] = 1'b0;
			end
			if (reg_wr_i && reg_addr_i == TOC_REG_FLAGS && reg_wdata_i[i]) begin
				d.flag[i] = 1'b0;
			end
			if (timer_tick_i && q.pend[i]) begin
				d.flag[i] = 1'b1;
			end

			// output state update on a real match; action read live
			if (real_match[i]) begin
				if (!pwm) begin
					d.ocs[i] = plain_action(q.act[i], q.ocs[i]);
				end else begin
					case (q.act[i])
						TOC_ACT_CLEAR: d.ocs[i] = 1'b0;
						TOC_ACT_SET: d.ocs[i] = 1'b1;
						// toggle only meaningful on channel A
						TOC_ACT_TOGGLE: d.ocs[i] = (i == 0) ? ~q.ocs[i] : q.ocs[i];
						default: d.ocs[i] = q.ocs[i];
					endcase
				end
			end
			// single slope: BOTTOM restores the idle level of the pulse
			if (fast && timer_tick_i && counter_at_bottom_i) begin
				if (q.act[i] == TOC_ACT_CLEAR) begin
					d.ocs[i] = 1'b1;
				end else if (q.act[i] == TOC_ACT_SET) begin
					d.ocs[i] = 1'b0;
				end
			end
			// force strobe: output only, no flag, no counter clear
			if (reg_wr_i && reg_addr_i == TOC_REG_FORCE && reg_wdata_i[i] && !pwm) begin
				d.ocs[i] = plain_action(q.act[i], q.ocs[i]);
			end
		end

		// ---------------- register writes ----------------
		if (reg_wr_i) begin
			case (reg_addr_i)
				// mode change leaves output states untouched
				TOC_REG_MODE: d.mode = reg_wdata_i[3:0];
				TOC_REG_ACTION: begin
					d.act[0] = reg_wdata_i[TOC_ACT_W-1:0];
					d.act[1] = reg_wdata_i[TOC_ACT_B_POS +: TOC_ACT_W];
				end
				TOC_REG_IRQEN: d.irq_en = reg_wdata_i[1:0];
				// high bytes only load the shared latch
				TOC_REG_CMPA_HI, TOC_REG_CMPB_HI: d.temp = reg_wdata_i;
				TOC_REG_CMPA_LO: begin
					if (pwm) begin
						d.cmp_buf[0] = wr_val;
					end else begin
						d.cmp_act[0] = wr_val;
					end
				end
				TOC_REG_CMPB_LO: begin
					if (pwm) begin
						d.cmp_buf[1] = wr_val;
					end else begin
						d.cmp_act[1] = wr_val;
					end
				end
				default: ;
			endcase
		end

		// ---------------- register reads ----------------
		// compare bytes come straight from the register, not the latch
		case (reg_addr_i)
			TOC_REG_MODE: rd_val = {4'h0, q.mode};
			TOC_REG_ACTION: rd_val = {4'h0, q.act[1], q.act[0]};
			TOC_REG_IRQEN: rd_val = {6'h00, q.irq_en};
			TOC_REG_FLAGS: rd_val = {6'h00, q.flag};
			TOC_REG_CMPA_LO: rd_val = pwm ? q.cmp_buf[0][7:0] : q.cmp_act[0][7:0];
			TOC_REG_CMPA_HI: rd_val = pwm ? q.cmp_buf[0][15:8] : q.cmp_act[0][15:8];
			TOC_REG_CMPB_LO: rd_val = pwm ? q.cmp_buf[1][7:0] : q.cmp_act[1][7:0];
			TOC_REG_CMPB_HI: rd_val = pwm ? q.cmp_buf[1][15:8] : q.cmp_act[1][15:8];
			default: rd_val = TOC_BYTE_RST;
		endcase
		d.rdata = reg_rd_i ? rd_val : TOC_BYTE_RST;

		// ---------------- registered outputs ----------------
		d.irq = d.flag & d.irq_en;
		for (int i = 0; i < TOC_NCH; i++) begin
			// port override whenever any action bit is set; capture untouched
			d.pin_out[i] = (d.act[i] != TOC_ACT_NONE) ? d.ocs[i] : port_data_i[i];
		end
		d.pin_oe = pin_direction_bit_i;
		d.top_value = d.cmp_act[0];
		d.top_from_a = a_is_top(d.mode);
		d.top_match = real_match[0] & a_is_top(q.mode);
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			q <= TOC_STATE_RST;
		end else begin
			q <= d;
		end
	end

	// outputs straight from the state flops
	assign reg_rdata_o = q.rdata;
	assign pin_out_o = q.pin_out;
	assign pin_oe_o = q.pin_oe;
	assign irq_o = q.irq;
	assign waveform_mode_sel_o = q.mode;
	assign top_value_o = q.top_value;
	assign top_from_a_o = q.top_from_a;
	assign top_match_o = q.top_match;

endmodule : toc_unit

// >>> verilog/toc_pkg.sv
package toc_pkg;

	// ------------------------------------------------------------
	// register map (byte-wide registers on the plain port)
	// ------------------------------------------------------------
	localparam int TOC_ADDR_W = 4;
	localparam logic [3:0] TOC_REG_MODE = 4'h0;
	localparam logic [3:0] TOC_REG_ACTION = 4'h1;
	localparam logic [3:0] TOC_REG_FORCE = 4'h2;
	localparam logic [3:0] TOC_REG_IRQEN = 4'h3;
	localparam logic [3:0] TOC_REG_FLAGS = 4'h4;
	localparam logic [3:0] TOC_REG_CMPA_LO = 4'h5;
	localparam logic [3:0] TOC_REG_CMPA_HI = 4'h6;
	localparam logic [3:0] TOC_REG_CMPB_LO = 4'h7;
	localparam logic [3:0] TOC_REG_CMPB_HI = 4'h8;

	// ------------------------------------------------------------
	// field positions and widths
	// ------------------------------------------------------------
	localparam int TOC_NCH = 2;
	localparam int TOC_ACT_W = 2;
	localparam int TOC_ACT_B_POS = 2;

	// ------------------------------------------------------------
	// waveform mode selection values
	// ------------------------------------------------------------
	localparam logic [3:0] TOC_WGM_NORMAL = 4'h0;
	localparam logic [3:0] TOC_WGM_CTC_A = 4'h4;
	localparam logic [3:0] TOC_WGM_CTC_CAP = 4'hc;
	localparam logic [3:0] TOC_WGM_RESERVED = 4'hd;
	localparam logic [3:0] TOC_WGM_FAST_8 = 4'h5;
	localparam logic [3:0] TOC_WGM_FAST_9 = 4'h6;
	localparam logic [3:0] TOC_WGM_FAST_10 = 4'h7;
	localparam logic [3:0] TOC_WGM_FAST_CAP = 4'he;
	localparam logic [3:0] TOC_WGM_FAST_A = 4'hf;
	localparam logic [3:0] TOC_WGM_PFC_A = 4'h9;
	localparam logic [3:0] TOC_WGM_PC_A = 4'hb;

	// ------------------------------------------------------------
	// output action selection codes
	// ------------------------------------------------------------
	localparam logic [1:0] TOC_ACT_NONE = 2'h0;
	localparam logic [1:0] TOC_ACT_TOGGLE = 2'h1;
	localparam logic [1:0] TOC_ACT_CLEAR = 2'h2;
	localparam logic [1:0] TOC_ACT_SET = 2'h3;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [15:0] TOC_CMP_RST = 16'h0000;
	localparam logic [7:0] TOC_BYTE_RST = 8'h00;
	localparam logic [3:0] TOC_MODE_RST = 4'h0;

	// ------------------------------------------------------------
	// whole state of the unit
	// ------------------------------------------------------------
	typedef struct packed {
		logic [3:0] mode;
		logic [1:0][1:0] act;
		logic [1:0][15:0] cmp_act;
		logic [1:0][15:0] cmp_buf;
		logic [7:0] temp;
		logic [1:0] irq_en;
		logic [1:0] flag;
		logic [1:0] pend;
		logic block;
		logic [1:0] ocs;
		logic [7:0] rdata;
		logic [1:0] irq;
		logic [1:0] pin_out;
		logic [1:0] pin_oe;
		logic [15:0] top_value;
		logic top_from_a;
		logic top_match;
	} toc_state_s;

	localparam toc_state_s TOC_STATE_RST = '{
		mode: TOC_MODE_RST,
		act: '{TOC_ACT_NONE, TOC_ACT_NONE},
		cmp_act: '{TOC_CMP_RST, TOC_CMP_RST},
		cmp_buf: '{TOC_CMP_RST, TOC_CMP_RST},
		temp: TOC_BYTE_RST,
		irq_en: 2'h0,
		flag: 2'h0,
		pend: 2'h0,
		block: 1'b0,
		ocs: 2'h0,
		rdata: TOC_BYTE_RST,
		irq: 2'h0,
		pin_out: 2'h0,
		pin_oe: 2'h0,
		top_value: TOC_CMP_RST,
		top_from_a: 1'b0,
		top_match: 1'b0
	};

endpackage : toc_pkg

// >>> tb/toc_cnt_model.sv
`timescale 1ns/10ps
module toc_cnt_model (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic run_i,
	input wire logic slow_i,
	input wire logic load_i,
	input wire logic [15:0] load_val_i,
	input wire logic [15:0] top_i,
	output logic [15:0] count_o,
	output logic tick_o,
	output logic at_top_o,
	output logic at_bottom_o,
	output logic wr_o
);
	logic ph_q;
	// slow mode ticks only every other cycle
	assign tick_o = run_i & (~slow_i | ph_q);
	assign at_top_o = count_o == top_i;
	assign at_bottom_o = count_o == 16'h0000;
	assign wr_o = load_i; // cpu write flagged in its own cycle
	// a cpu load overrides counting
	always_ff @(posedge clk_i) begin
		ph_q <= ~ph_q & resetn_i;
		if (!resetn_i) begin
			count_o <= 16'h0000;
		end else if (load_i) begin
			count_o <= load_val_i;
		end else if (tick_o) begin
			count_o <= at_top_o ? 16'h0000 : count_o + 16'h0001;
		end
	end
endmodule : toc_cnt_model

// >>> tb/toc_unit_assertions.sv
`timescale 1ns/10ps
module toc_unit_assertions
	import toc_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [TOC_ADDR_W-1:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic [1:0] port_data_i,
	input wire logic [1:0] pin_direction_bit_i,
	input wire logic [1:0] pin_out_o,
	input wire logic [1:0] pin_oe_o,
	input wire logic [1:0] irq_o
);
	logic [3:0] mode_q, act_q;
	logic [1:0] en_q;
	// shadow of the fields the properties lean on
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			mode_q <= 4'h0;
			act_q <= 4'h0;
			en_q <= 2'h0;
		end else if (reg_wr_i) begin
			if (reg_addr_i == TOC_REG_MODE) mode_q <= reg_wdata_i[3:0];
			if (reg_addr_i == TOC_REG_ACTION) act_q <= reg_wdata_i[3:0];
			if (reg_addr_i == TOC_REG_IRQEN) en_q <= reg_wdata_i[1:0];
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	// reads, and any cycle whose previous cycle was out of reset
	sequence rd_s(a);
		reg_rd_i && reg_addr_i == a;
	endsequence
	sequence run_s;
		$past(resetn_i);
	endsequence
	rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
		else $error("read data outside a read");
	mode_read_a: assert property (rd_s(TOC_REG_MODE) |=> reg_rdata_o == {4'h0, $past(mode_q)})
		else $error("mode read back");
	act_read_a: assert property (rd_s(TOC_REG_ACTION) |=> reg_rdata_o == {4'h0, $past(act_q)})
		else $error("action read back");
	hole_read_a: assert property (reg_rd_i && reg_addr_i > TOC_REG_CMPB_HI |=> reg_rdata_o == 8'h00)
		else $error("unmapped read");
	irq_gate_a: assert property ((irq_o & ~en_q) == 2'h0)
		else $error("irq without enable");
	// the pin source follows the action as it stands after the last edge
	pin_src_a: assert property (run_s ##0 act_q[1:0] == 2'h0 |-> pin_out_o[0] == $past(port_data_i[0]))
		else $error("pin source");
	oe_follow_a: assert property (run_s |-> pin_oe_o == $past(pin_direction_bit_i))
		else $error("pin enable");
	reset_zero_a: assert property (disable iff (1'b0) !resetn_i |=> pin_out_o == 2'h0 && irq_o == 2'h0)
		else $error("outputs after reset");
endmodule : toc_unit_assertions

bind toc_unit toc_unit_assertions u_chk (.clk_i(clk_i), .resetn_i(resetn_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .port_data_i(port_data_i),
	.pin_direction_bit_i(pin_direction_bit_i), .pin_out_o(pin_out_o),
	.pin_oe_o(pin_oe_o), .irq_o(irq_o));

// >>> tb/tb.sv
`timescale 1ns/10ps
module tb
	import toc_pkg::*;
;
	logic clk_i = 1'b0, resetn_i = 1'b0;
	logic wr = 1'b0, rd = 1'b0, rd_q = 1'b0, run = 1'b0, slow = 1'b0, load = 1'b0;
	logic [3:0] addr = 4'h0, msel;
	logic [7:0] wdata = 8'h00, rdata;
	logic [15:0] lval = 16'h0000, topv = 16'hffff, cnt, tval, v, w;
	logic [1:0] ack = 2'h0, pdat = 2'h0, dir = 2'h0, pout, irq;
	logic tick, top, bot, cwr, e, tfa, tmatch;
	logic [7:0] exp_q[$];
	int miscompares = 0, check_count = 0, cyc = 0, tm_cnt = 0;

	toc_cnt_model u_cnt (.clk_i(clk_i), .resetn_i(resetn_i), .run_i(run), .slow_i(slow),
		.load_i(load), .load_val_i(lval), .top_i(topv), .count_o(cnt), .tick_o(tick),
		.at_top_o(top), .at_bottom_o(bot), .wr_o(cwr));
	toc_unit DUT (.clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .counter_value_i(cnt),
		.timer_tick_i(tick), .counter_at_top_i(top), .counter_at_bottom_i(bot),
		.counter_write_i(cwr), .irq_ack_i(ack), .port_data_i(pdat),
		.pin_direction_bit_i(dir), .pin_out_o(pout), .pin_oe_o(), .irq_o(irq),
		.waveform_mode_sel_o(msel), .top_value_o(tval), .top_from_a_o(tfa),
		.top_match_o(tmatch));

	task automatic chk(input logic [15:0] got, input logic [15:0] want);
		check_count++;
		if (got !== want) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, got, want);
		end
	endtask : chk
	task automatic end_sim();
		if (miscompares == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_sim
	// strobes stay up between back to back calls, so each edge sees one request
	task automatic bus(input logic w1, input logic r1, input logic [3:0] a, input logic [7:0] d);
		wr <= w1;
		rd <= r1;
		addr <= a;
		wdata <= d;
		@(posedge clk_i);
	endtask : bus
	task automatic wr8(input logic [3:0] a, input logic [7:0] d);
		bus(1'b1, 1'b0, a, d);
	endtask : wr8
	task automatic idle(input int n);
		repeat (n) bus(1'b0, 1'b0, 4'h0, 8'h00);
	endtask : idle
	task automatic rd8(input logic [3:0] a, input logic [7:0] x);
		exp_q.push_back(x);
		bus(1'b0, 1'b1, a, 8'h00);
	endtask : rd8
	task automatic wcmp(input logic [3:0] lo, input logic [15:0] x);
		wr8(lo + 4'h1, x[15:8]);
		wr8(lo, x[7:0]);
	endtask : wcmp
	task automatic pin(input logic x);
		chk(16'(pout[0]), 16'(x));
	endtask : pin
	// load the count, let it run ten cycles, then stop and settle
	task automatic pass(input logic [15:0] start);
		lval <= start;
		load <= 1'b1;
		idle(1);
		load <= 1'b0;
		run <= 1'b1;
		idle(10);
		run <= 1'b0;
		idle(3);
	endtask : pass

	initial forever #5 clk_i = ~clk_i;
	// read data stands only in the cycle after the strobe
	always @(posedge clk_i) begin
		rd_q <= rd;
		cyc <= cyc + 1;
		if (rd_q) chk(16'(rdata), 16'(exp_q.pop_front()));
		// top match is a one-cycle pulse: count every one seen
		if (tmatch) tm_cnt <= tm_cnt + 1;
		if (cyc == 2000) begin
			$display("unexpected at %0t: timeout", $time);
			miscompares++;
			end_sim();
		end
	end

	initial begin
		v = 16'($urandom(32'he24b236c)) & 16'h7fff | 16'h0100;
		w = 16'($urandom) | 16'h0100; // keeps w clear of the counts just after a wrap
		idle(20);
		resetn_i <= 1'b1;
		idle(1);
		for (int i = 0; i < 16; i++) rd8(4'(i), 8'h00);
		chk(16'(pout), 16'h0000);
		dir <= 2'b11;
		pdat <= 2'($urandom);
		wr8(TOC_REG_MODE, {5'h00, w[2:0]});
		rd8(TOC_REG_MODE, {5'h00, w[2:0]});
		wr8(TOC_REG_MODE, 8'h00);
		wcmp(TOC_REG_CMPA_LO, v);
		wcmp(TOC_REG_CMPB_LO, {v[15:8] + 8'h10, w[7:0]});
		wr8(TOC_REG_CMPB_LO, w[15:8]); // low byte alone reuses the latch
		rd8(TOC_REG_CMPA_LO, v[7:0]);
		rd8(TOC_REG_CMPA_HI, v[15:8]);
		rd8(TOC_REG_CMPB_HI, v[15:8] + 8'h10);
		rd8(TOC_REG_CMPB_LO, w[15:8]);
		idle(1);
		chk(tval, v);
		chk(16'(tfa), 16'h0000);
		// known state by force, then walk toggle, clear and set
		wr8(TOC_REG_ACTION, {6'h00, TOC_ACT_SET});
		wr8(TOC_REG_FORCE, 8'h01);
		e = 1'b1;
		idle(2);
		pin(e);
		rd8(TOC_REG_FLAGS, 8'h00);
		for (int i = 1; i < 4; i++) begin
			slow <= i[0];
			wr8(TOC_REG_ACTION, {6'h00, 2'(i)});
			pass(v - 16'h0003);
			e = (i == 1) ? ~e : (i == 3);
			pin(e);
			rd8(TOC_REG_FLAGS, 8'h01);
			wr8(TOC_REG_FLAGS, 8'h00);
			rd8(TOC_REG_FLAGS, 8'h01);
			wr8(TOC_REG_FLAGS, 8'h01);
			rd8(TOC_REG_FLAGS, 8'h00);
		end
		wr8(TOC_REG_ACTION, 8'h00);
		pass(v - 16'h0003);
		chk(16'(pout[0]), 16'(pdat[0]));
		wr8(TOC_REG_ACTION, {6'h00, TOC_ACT_TOGGLE});
		wr8(TOC_REG_FLAGS, 8'h01);
		pin(e);
		pass(v);
		pin(e);
		rd8(TOC_REG_FLAGS, 8'h00);
		wr8(TOC_REG_IRQEN, 8'h01);
		pass(v - 16'h0003);
		e = ~e;
		chk(16'(irq), 16'h0001);
		ack <= 2'h1;
		idle(1);
		ack <= 2'h0;
		idle(3);
		chk(16'(irq), 16'h0000);
		rd8(TOC_REG_FLAGS, 8'h00);
		// fast pwm with top from channel a: writes wait in the buffer
		wr8(TOC_REG_MODE, {4'h0, TOC_WGM_FAST_A});
		wr8(TOC_REG_FORCE, 8'h01);
		wcmp(TOC_REG_CMPA_LO, w);
		rd8(TOC_REG_CMPA_LO, w[7:0]);
		idle(2);
		pin(e);
		chk(16'(msel), 16'(TOC_WGM_FAST_A));
		chk(16'(tfa), 16'h0001);
		chk(tval, v);
		topv <= 16'h0010;
		pass(16'h000e);
		chk(tval, w);
		// counter loaded equal to top: that top match must be lost
		topv <= w;
		pass(w);
		chk(16'(tm_cnt), 16'h0000);
		pass(w - 16'h0003);
		chk(16'(tm_cnt), 16'h0001);
		// every mode code: mode select output and whether channel a sets top
		for (int m = 0; m < 16; m++) begin
			wr8(TOC_REG_MODE, 8'(m));
			idle(1);
			chk(16'(msel), 16'(m));
			chk(16'(tfa), 16'(m == TOC_WGM_CTC_A || m == TOC_WGM_FAST_A || m == TOC_WGM_PFC_A || m == TOC_WGM_PC_A));
		end
		idle(2);
		end_sim();
	end
endmodule : tb
